/* File: bench/lmx_host_decode_chk.sv */
/*
  port assertions for the host decoder: readback framing and row output.
  assumes one clock domain and synchronous active-high reset.
*/
`default_nettype none
module lmx_host_decode_chk #(
  parameter int PLANE_TICK = 50
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  input wire logic dout_o,
  input wire logic dout_oe_o,
  input wire logic [7:0] driver_addr_i,
  input wire logic [1:0] plane_o,
  input wire logic [7:0] row_data_o,
  input wire logic [3:0] row_sel_o,
  input wire logic row_valid_o,
  input wire logic row_ready_i
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  logic sclk_q;
  logic seen_r;
  logic [4:0] nbit_r;
  logic [23:0] sh_r;
  logic [3:0] nfall_r;
  logic [3:0] sel_r;

  // bit count is cleared while cs is high, so its value at the cs rise survives one cycle
  always_ff @(posedge clk_i)
  begin
    sclk_q <= sclk_i;
    if (srst_i || cs_n_i)
      nbit_r <= 5'h00;
    else if (sclk_i && !sclk_q)
      nbit_r <= nbit_r + 5'h01;
    if (!cs_n_i && sclk_i && !sclk_q)
      sh_r <= {sh_r[22:0], din_i};
    if (srst_i || !dout_oe_o)
      nfall_r <= 4'h0;
    else if (!sclk_i && sclk_q)
      nfall_r <= nfall_r + 4'h1;
    if (srst_i)
      seen_r <= 1'b0;
    else if (row_valid_o && row_ready_i)
      seen_r <= 1'b1;
    if (row_valid_o && row_ready_i)
      sel_r <= row_sel_o;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_reset_quiet: assert property (disable iff (1'b0)
    srst_i |=> !dout_oe_o && !row_valid_o && plane_o == 2'h0)
    else $error("outputs not cleared by reset");
  a_oe_after_cs: assert property ($rose(dout_oe_o) |-> $past(cs_n_i) && !$past(cs_n_i, 2))
    else $error("readback enabled without cs rise");
  a_read_cmd: assert property ($rose(dout_oe_o) |->
    ($past(nbit_r) == 5'h10 && $past(sh_r[15])) || ($past(nbit_r) == 5'h18 && $past(sh_r[23])))
    else $error("readback without a read command");
  a_oe_cs_idle: assert property (dout_oe_o |-> $past(cs_n_i))
    else $error("readback kept after cs fall");
  a_dout_hold: assert property (dout_oe_o && $past(dout_oe_o) &&
    !($past(sclk_i, 2) && !$past(sclk_i)) |-> $stable(dout_o))
    else $error("readback bit moved without sclk fall");
  a_oe_ends: assert property (nfall_r == 4'h8 |-> !dout_oe_o)
    else $error("readback longer than eight bits");
  a_row_hold: assert property (row_valid_o && !row_ready_i |=>
    row_valid_o && $stable(row_data_o) && $stable(row_sel_o))
    else $error("row word changed before taken");
  a_row_order: assert property (row_valid_o && row_ready_i && seen_r |->
    row_sel_o == sel_r + 4'h1)
    else $error("row steps out of order");

  c_read: cover property ($rose(dout_oe_o));
  c_stall: cover property (row_valid_o && !row_ready_i [*3]);
  c_take: cover property (row_valid_o && row_ready_i);
endmodule

bind lmx_host_decode lmx_host_decode_chk #(.PLANE_TICK(PLANE_TICK)) chk_u (
  .clk_i(clk_i), .srst_i(srst_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i), .din_i(din_i),
  .dout_o(dout_o), .dout_oe_o(dout_oe_o), .driver_addr_i(driver_addr_i),
  .plane_o(plane_o), .row_data_o(row_data_o), .row_sel_o(row_sel_o),
  .row_valid_o(row_valid_o), .row_ready_i(row_ready_i));
`default_nettype wire

/* File: bench/lmx_host_decode_tb.sv */
/*
  self-checking bench for the host decoder with a host bus model.
  assumes the package and design files are compiled first.
*/
`default_nettype none
module lmx_host_decode_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic row_ready_i = 1'b0;
  logic [7:0] drv = 8'h00;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe;
  logic [1:0] plane;
  logic [7:0] rdata;
  logic [3:0] rsel;
  logic rv;
  int sfb = 0;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  int lens[5] = '{7, 9, 15, 17, 23};

  always #25 clk_i = ~clk_i;

  lmx_host_decode #(.PLANE_TICK(50)) dut_u (
    .clk_i(clk_i), .srst_i(srst_i), .cs_n_i(cs_n), .sclk_i(sclk), .din_i(din),
    .dout_o(dout), .dout_oe_o(dout_oe), .driver_addr_i(drv), .plane_o(plane),
    .row_data_o(rdata), .row_sel_o(rsel), .row_valid_o(rv), .row_ready_i(row_ready_i));
  lmx_host_model host_u (.clk_i(clk_i), .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din),
    .dout_i(dout), .dout_oe_i(dout_oe));

  // long early stall fills the row buffer before random draining
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    row_ready_i <= (cyc > 3000) && ($urandom_range(3, 0) != 0);
  end

  // super frame index of the next row word: row 15 words close a frame
  always @(posedge clk_i)
  begin
    if (rv && row_ready_i && rsel == 4'hf)
      sfb <= (sfb == 11) ? 0 : sfb + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr16(input logic glob, input logic [3:0] idx, input logic [7:0] d);
    host_u.xfer(16, {8'h00, host_u.cmd16(1'b0, 1'b0, glob, idx, d)});
  endtask

  task automatic rd16(input logic ai, input logic [3:0] idx, output logic [8:0] r);
    host_u.xfer(16, {8'h00, host_u.cmd16(1'b1, ai, 1'b0, idx, 8'h00)});
    host_u.read8(r);
  endtask

  task automatic rd24(input logic [13:0] a, output logic [8:0] r);
    host_u.xfer(24, {2'b10, a, 8'h00});
    host_u.read8(r);
  endtask

  // mono single-bit layout: plane, driver, byte
  function automatic logic [13:0] a1(input logic [1:0] p, input logic [7:0] d,
      input logic [3:0] b);
    return {p, d, b};
  endfunction

  // panel address of a local byte for each {pi, color} layout
  function automatic logic [13:0] pa(input logic [1:0] md, input logic [7:0] d,
      input logic [13:0] r);
    case (md)
      2'h1: return {r[13:11], d, r[2:0]};
      2'h2: return {r[13], d, r[4:0]};
      default: return {r[13:12], d, r[3:0]};
    endcase
  endfunction

  // enables for pixel levels 0..3 in each nibble; g picks the geometric scale
  function automatic logic [7:0] fm(input int s, input logic g);
    logic lo;
    logic hi;
    lo = g ? (s % 4 == 1) : (s % 3 == 1);
    hi = g ? (s % 2 == 0) : (s % 3 != 1);
    return {1'b1, hi, lo, 1'b0, 1'b1, hi, lo, 1'b0};
  endfunction

  initial
  begin
    repeat (50000) @(posedge clk_i);
    miscompares++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [8:0] r;
    logic [13:0] a;
    logic [7:0] v;
    logic [1:0] p;
    logic [13:0] b;
    int n;
    void'($urandom(32'hf107));
    @(posedge clk_i);
    drv <= 8'($urandom_range(254, 0));
    p = 2'($urandom_range(3, 0));
    v = 8'($urandom);
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    check({dout_oe, 6'h00, plane}, 9'h000);
    wr16(1'b1, lmx_pkg::REG_DRV_PTR, drv);
    rd16(1'b1, lmx_pkg::REG_DRV_PTR, r);
    check(r, {1'b1, drv});
    rd16(1'b0, lmx_pkg::REG_DRV_PTR, r);
    check(r, 9'h000);
    wr16(1'b0, lmx_pkg::REG_RATE, ~v);
    wr16(1'b1, lmx_pkg::REG_DRV_PTR, drv);
    rd16(1'b0, lmx_pkg::REG_RATE, r);
    check(r, 9'h100);
    wr16(1'b1, lmx_pkg::REG_RATE, v);
    rd16(1'b0, lmx_pkg::REG_RATE, r);
    check(r, {1'b1, v});
    // third byte runs into the next driver's segment
    a = a1(p, drv, 4'he);
    wr16(1'b1, lmx_pkg::REG_DISP_HI, {2'b00, a[13:8]});
    wr16(1'b1, lmx_pkg::REG_DISP_LO, a[7:0]);
    for (int i = 0; i < 3; i++)
      host_u.xfer(8, {16'h0000, v ^ 8'(i)});
    rd24(a, r);
    check(r, {1'b1, v});
    rd24(a + 14'h1, r);
    check(r, {1'b1, v ^ 8'h01});
    rd24(a + 14'h2, r);
    check(r, 9'h000);
    rd24(a1(p, drv, 4'h0), r);
    check(r, 9'h100);
    rd16(1'b0, lmx_pkg::REG_DISP_LO, r);
    check(r, {1'b1, a[7:0] + 8'h03});
    foreach (lens[i])
      host_u.xfer(lens[i], 24'($urandom));
    rd16(1'b0, lmx_pkg::REG_DISP_LO, r);
    check(r, {1'b1, a[7:0] + 8'h03});
    // every layout twice: own segment answers, a foreign one stays silent
    for (int i = 0; i < 8; i++)
    begin
      wr16(1'b1, lmx_pkg::REG_PANEL, {6'h00, 2'(i)});
      b = 14'($urandom);
      if (i == 2)
        b[4:0] = 5'h1f;
      a = pa(2'(i), drv, b);
      v = 8'($urandom);
      host_u.xfer(24, {2'b00, a, v});
      rd24(a, r);
      check(r, {1'b1, v});
      rd24(pa(2'(i), drv ^ 8'h80, b), r);
      check(r, 9'h000);
    end
    // pair 2bpp: red rows arithmetic, green rows geometric, plane 0 shown
    wr16(1'b1, lmx_pkg::REG_PANEL, 8'h0b);
    for (int k = 0; k < 32; k++)
      host_u.xfer(24, {3'b000, 1'(k >> 4), drv, 4'(k), 8'he4});
    // words already buffered may hold the old image
    repeat (3) @(negedge clk_i iff (rv && row_ready_i));
    repeat (64)
    begin
      @(negedge clk_i iff (rv && row_ready_i));
      check({1'b0, rdata}, {1'b0, fm(sfb, rsel[3])});
    end
    // auto plane: two units of the plane tick between changes
    wr16(1'b1, lmx_pkg::REG_RATE, 8'h02);
    wr16(1'b1, lmx_pkg::REG_PLANE, 8'h40);
    for (int k = 0; k < 2; k++)
    begin
      p = plane;
      n = 0;
      while (plane == p && n < 300)
      begin
        @(negedge clk_i);
        n++;
      end
    end
    check(9'(n), 9'h064);
    check({7'h00, plane}, {8'h00, ~p[0]});
    give_verdict();
  end
endmodule
`default_nettype wire

/* File: bench/lmx_host_model.sv */
/*
  host side of the shared four-wire serial bus: frames words of up to 24 bits
  and clocks back one readback byte.
  assumes the decoder samples the pins on clk_i and needs 2-cycle phases.
*/
`default_nettype none
module lmx_host_model (
  input wire logic clk_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic din_o,
  input wire logic dout_i,
  input wire logic dout_oe_i
);
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // reserved bit d12 is always sent as zero
  function automatic logic [15:0] cmd16(input logic rd, input logic ai, input logic glob,
      input logic [3:0] idx, input logic [7:0] d);
    return {rd, ai, glob, 1'b0, idx, d};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // sclk stays low whenever cs changes; msb first
  task automatic xfer(input int n, input logic [23:0] w);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      tick(1);
      din_o <= w[i];
      tick(1);
      sclk_o <= 1'b1;
      tick(2);
      sclk_o <= 1'b0;
    end
    tick(2);
    cs_n_o <= 1'b1;
    din_o <= ~din_o; // no stale data level between frames
    tick(3);
  endtask

  // r[8] tells whether any driver answered at all
  task automatic read8(output logic [8:0] r);
    r = 9'h000;
    tick(1);
    if (dout_oe_i === 1'b1)
    begin
      r[8] = 1'b1;
      for (int i = 7; i >= 0; i--)
      begin
        r[i] = dout_i;
        sclk_o <= 1'b1;
        tick(2);
        sclk_o <= 1'b0;
        tick(3);
      end
    end
    tick(2);
  endtask
endmodule
`default_nettype wire

/* File: hdl/lmx_buf2.sv */
/*
  two-entry buffer with valid/ready on both sides. flags are flops so the
  valid output needs no logic after it and ready is only the inverted v1_r.
*/
`default_nettype none
module lmx_buf2 #(
  parameter int W = 12
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  logic v0_r, v0_nxt, v1_r, v1_nxt;
  logic [W-1:0] d0_r, d0_nxt, d1_r, d1_nxt;
  logic push, pop;

  assign push = in_valid_i & ~v1_r;
  assign pop = v0_r & out_ready_i;

  always_comb
  begin
    v0_nxt = v0_r;
    v1_nxt = v1_r;
    d0_nxt = d0_r;
    d1_nxt = d1_r;
    if (pop)
    begin
      d0_nxt = d1_r;
      v0_nxt = v1_r;
      v1_nxt = 1'b0;
    end
    if (push)
    begin
      if (pop ? ~v1_r : ~v0_r)
      begin
        d0_nxt = in_data_i;
        v0_nxt = 1'b1;
      end
      else
      begin
        d1_nxt = in_data_i;
        v1_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      v0_r <= 1'b0;
      v1_r <= 1'b0;
      d0_r <= '0;
      d1_r <= '0;
    end
    else
    begin
      v0_r <= v0_nxt;
      v1_r <= v1_nxt;
      d0_r <= d0_nxt;
      d1_r <= d1_nxt;
    end
  end

  assign in_ready_o = ~v1_r;
  assign out_valid_o = v0_r;
  assign out_data_o = d0_r;
endmodule
`default_nettype wire

/* File: hdl/lmx_frame_mod.sv */
/*
  frame modulation: turns 2-bit pixel levels into per-cycle enables over a
  12-cycle super frame. purely combinational; caller supplies the cycle.
*/
`default_nettype none
module lmx_frame_mod (
  input wire logic [3:0] sf_i,
  input wire logic [15:0] level_i,
  input wire logic geo_i,
  output logic [7:0] en_o
);
  logic ph3;
  logic ph4;
  logic even;

  assign ph3 = (sf_i == 4'h1) || (sf_i == 4'h4) || (sf_i == 4'h7) || (sf_i == 4'ha);
  assign ph4 = (sf_i[1:0] == 2'h1);
  assign even = ~sf_i[0];

  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_pix
      always_comb
      begin
        case (level_i[2*i+1 -: 2])
          lmx_pkg::LVL_FULL: en_o[i] = 1'b1;
          lmx_pkg::LVL_HI: en_o[i] = geo_i ? even : ~ph3;
          lmx_pkg::LVL_LO: en_o[i] = geo_i ? ph4 : ph3;
          default: en_o[i] = 1'b0;
        endcase
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* File: hdl/lmx_host_decode.sv */
/*
  host command decoder for one chained led matrix driver: serial receive,
  8/16/24-bit decode, configuration registers, 64-byte display memory,
  plane sequencing and frame-modulated row refresh.
  assumes host pins are synchronous to clk_i and driver_addr_i is the
  address allocated by the chain bus, stable while commands arrive.
*/
// Functional notes
// - super frame enable patterns per level
// - panel layout from intensity and color bits
// - 64 bytes, four or two planes
// - plane chosen by command or auto rate
// - refresh one plane, others stay writable
// - 14-bit panel address shared by drivers
// - host sees contiguous planes, red then green
// - every driver decodes every transmission
// - 8-bit write goes to display pointer
// - 8-bit writes only, pointer auto-increments
// - 16-bit command field layout
// - register write global or pointer-selected
// - register read only from selected driver
// - auto-increment driver pointer after routed command
// - mono 1bpp direct address layout
// - color-pair 1bpp direct address layout
// - 2bpp direct address, plane 0 or 1
// - top bit reads, last byte is data
// - ignore lengths other than 8/16/24
`default_nettype none
module lmx_host_decode #(
  parameter int PLANE_TICK = lmx_pkg::PLANE_TICK_CYC
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_o,
  input wire logic [7:0] driver_addr_i,
  output logic [1:0] plane_o,
  output logic [7:0] row_data_o,
  output logic [3:0] row_sel_o,
  output logic row_valid_o,
  input wire logic row_ready_i
);
  ////////////////////////////////////////////////////////////////////////
  logic cs_q_r, sclk_q_r;
  logic [4:0] bits_r, bits_nxt;
  logic [23:0] sh_r, sh_nxt;
  logic [7:0] reg_r [lmx_pkg::NUM_REGS];
  logic [7:0] reg_nxt [lmx_pkg::NUM_REGS];
  logic [7:0] mem_r [lmx_pkg::MEM_BYTES];
  logic [7:0] mem_nxt [lmx_pkg::MEM_BYTES];
  logic rd_act_r, rd_act_nxt;
  logic [7:0] rd_sh_r, rd_sh_nxt;
  logic [2:0] rd_cnt_r, rd_cnt_nxt;
  logic dout_nxt, oe_nxt;
  logic cs_rise, cs_fall, sclk_rise, sclk_fall;
  logic pi, color;
  logic [1:0] plane_r, plane_nxt;

  assign cs_rise = cs_n_i & ~cs_q_r;
  assign cs_fall = ~cs_n_i & cs_q_r;
  assign sclk_rise = sclk_i & ~sclk_q_r;
  assign sclk_fall = ~sclk_i & sclk_q_r;
  assign pi = reg_r[lmx_pkg::REG_PANEL][lmx_pkg::PNL_PI];
  assign color = reg_r[lmx_pkg::REG_PANEL][lmx_pkg::PNL_COLOR];

  // panel address to {hit, local byte}; local layout puts red before green
  function automatic logic [6:0] map_addr(input logic [13:0] a, input logic p,
    input logic c, input logic [7:0] d);
    logic hit;
    logic [5:0] idx;
    begin
      if (!p && !c)
      begin
        hit = (a[11:4] == d);
        idx = {a[13:12], a[3:0]};
      end
      else if (!p)
      begin
        hit = (a[10:3] == d);
        idx = {a[13:12], a[11], a[2:0]};
      end
      else if (!c)
      begin
        hit = (a[12:5] == d);
        idx = {a[13], a[4:0]};
      end
      else
      begin
        hit = (a[11:4] == d);
        idx = {a[13], a[12], a[3:0]};
      end
      return {hit, idx};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // serial receive, decode, registers and display memory
  logic [13:0] disp_ptr;
  logic [6:0] m;
  logic [3:0] ra;
  logic [7:0] rdv;
  logic sel;

  assign disp_ptr = {reg_r[lmx_pkg::REG_DISP_HI][5:0], reg_r[lmx_pkg::REG_DISP_LO]};
  assign sel = (reg_r[lmx_pkg::REG_DRV_PTR] == driver_addr_i);
  assign ra = sh_r[11:8];

  always_comb
  begin
    rdv = reg_r[ra];
    if (ra == lmx_pkg::REG_PLANE)
    begin
      rdv[5:4] = plane_r;
    end
  end

  always_comb
  begin
    bits_nxt = bits_r;
    sh_nxt = sh_r;
    reg_nxt = reg_r;
    mem_nxt = mem_r;
    rd_act_nxt = rd_act_r;
    rd_sh_nxt = rd_sh_r;
    rd_cnt_nxt = rd_cnt_r;
    dout_nxt = dout_o;
    oe_nxt = dout_oe_o;
    m = '0;
    if (!cs_n_i && sclk_rise)
    begin
      sh_nxt = {sh_r[22:0], din_i};
      if (bits_r != lmx_pkg::LEN_SAT)
      begin
        bits_nxt = bits_r + 5'h01;
      end
    end
    if (cs_fall)
    begin
      bits_nxt = '0;
      rd_act_nxt = 1'b0; // host aborts a readback by lowering select
      oe_nxt = 1'b0;
    end
    else if (rd_act_r && sclk_fall)
    begin
      rd_cnt_nxt = rd_cnt_r + 3'h1;
      rd_sh_nxt = {rd_sh_r[6:0], 1'b0};
      dout_nxt = rd_sh_r[6];
      if (rd_cnt_r == 3'h7)
      begin
        rd_act_nxt = 1'b0;
        oe_nxt = 1'b0;
      end
    end
    // all drivers run the same decode; only content selects who acts
    if (cs_rise)
    begin
      if (bits_r == lmx_pkg::LEN_IND)
      begin
        m = map_addr(disp_ptr, pi, color, driver_addr_i);
        if (m[6])
        begin
          mem_nxt[m[5:0]] = sh_r[7:0];
        end
        {reg_nxt[lmx_pkg::REG_DISP_HI][5:0], reg_nxt[lmx_pkg::REG_DISP_LO]} =
          disp_ptr + 14'h0001;
      end
      else if (bits_r == lmx_pkg::LEN_CFG && !sh_r[lmx_pkg::CMD_RSV])
      begin
        if (sh_r[lmx_pkg::CMD_RW])
        begin
          if (sel)
          begin
            rd_sh_nxt = rdv;
            rd_act_nxt = 1'b1;
            rd_cnt_nxt = '0;
            dout_nxt = rdv[7];
            oe_nxt = 1'b1;
          end
        end
        else if (sh_r[lmx_pkg::CMD_GLOB] || sel)
        begin
          reg_nxt[ra] = sh_r[7:0];
        end
        if ((sh_r[lmx_pkg::CMD_RW] || !sh_r[lmx_pkg::CMD_GLOB]) && sh_r[lmx_pkg::CMD_AI])
        begin
          reg_nxt[lmx_pkg::REG_DRV_PTR] = reg_nxt[lmx_pkg::REG_DRV_PTR] + 8'h01;
        end
      end
      else if (bits_r == lmx_pkg::LEN_DIR)
      begin
        m = map_addr(sh_r[21:8], pi, color, driver_addr_i);
        if (m[6] && sh_r[lmx_pkg::DIR_RW])
        begin
          rd_sh_nxt = mem_r[m[5:0]];
          rd_act_nxt = 1'b1;
          rd_cnt_nxt = '0;
          dout_nxt = mem_r[m[5:0]][7];
          oe_nxt = 1'b1;
        end
        else if (m[6])
        begin
          mem_nxt[m[5:0]] = sh_r[7:0];
        end
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      cs_q_r <= 1'b1;
      sclk_q_r <= 1'b0;
      bits_r <= '0;
      sh_r <= '0;
      rd_act_r <= 1'b0;
      rd_sh_r <= '0;
      rd_cnt_r <= '0;
      dout_o <= 1'b0;
      dout_oe_o <= 1'b0;
      for (int i = 0; i < lmx_pkg::NUM_REGS; i++)
      begin
        reg_r[i] <= lmx_pkg::REG_RST;
      end
      for (int i = 0; i < lmx_pkg::MEM_BYTES; i++)
      begin
        mem_r[i] <= '0;
      end
    end
    else
    begin
      cs_q_r <= cs_n_i;
      sclk_q_r <= sclk_i;
      bits_r <= bits_nxt;
      sh_r <= sh_nxt;
      rd_act_r <= rd_act_nxt;
      rd_sh_r <= rd_sh_nxt;
      rd_cnt_r <= rd_cnt_nxt;
      dout_o <= dout_nxt;
      dout_oe_o <= oe_nxt;
      reg_r <= reg_nxt;
      mem_r <= mem_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // plane sequencing and row refresh
  lmx_pkg::lmx_rf_state_type st_r, st_nxt;
  logic [18:0] tick_r, tick_nxt;
  logic [5:0] sec_r, sec_nxt, chg_r, chg_nxt;
  logic [7:0] step_r, step_nxt;
  logic [3:0] row_r, row_nxt, sf_r, sf_nxt;
  logic tick, unit_tick, buf_rdy, geo;
  logic [5:0] rate_n;
  logic [15:0] level;
  logic [7:0] en;
  logic [7:0] ctl, rate;

  assign ctl = reg_r[lmx_pkg::REG_PLANE];
  assign rate = reg_r[lmx_pkg::REG_RATE];
  assign tick = (tick_r == 19'(PLANE_TICK - 1));
  assign unit_tick = tick && (!rate[lmx_pkg::RATE_SEC] ||
    sec_r == 6'(lmx_pkg::TICKS_PER_SEC - 1));
  assign rate_n = (rate[5:0] == 6'h00) ? 6'h01 : rate[5:0];

  // refresh reads only the shown plane; host writes reach any plane
  always_comb
  begin
    if (pi)
    begin
      level = {mem_r[{plane_r[0], row_r, 1'b0}], mem_r[{plane_r[0], row_r, 1'b1}]};
    end
    else
    begin
      for (int i = 0; i < 8; i++)
      begin
        level[2*i+1 -: 2] = {2{mem_r[{plane_r, row_r}][i]}};
      end
    end
    geo = (pi && color && row_r[3]) ? reg_r[lmx_pkg::REG_PANEL][lmx_pkg::PNL_GEO_GRN] :
      reg_r[lmx_pkg::REG_PANEL][lmx_pkg::PNL_GEO_RED];
  end

  lmx_frame_mod u_fm (
    .sf_i(sf_r),
    .level_i(level),
    .geo_i(geo),
    .en_o(en)
  );

  always_comb
  begin
    st_nxt = st_r;
    tick_nxt = tick ? '0 : tick_r + 19'h0_0001;
    sec_nxt = sec_r;
    chg_nxt = chg_r;
    plane_nxt = plane_r;
    step_nxt = (step_r == 8'(lmx_pkg::ROW_STEP_CYC - 1)) ? '0 : step_r + 8'h01;
    row_nxt = row_r;
    sf_nxt = sf_r;
    if (tick)
    begin
      sec_nxt = (sec_r == 6'(lmx_pkg::TICKS_PER_SEC - 1)) ? '0 : sec_r + 6'h01;
    end
    if (!ctl[lmx_pkg::PLN_AUTO])
    begin
      plane_nxt = pi ? {1'b0, ctl[0]} : ctl[1:0];
      chg_nxt = '0;
    end
    else if (unit_tick)
    begin
      chg_nxt = chg_r + 6'h01;
      if (chg_nxt >= rate_n)
      begin
        chg_nxt = '0;
        plane_nxt = pi ? {1'b0, ~plane_r[0]} : plane_r + 2'h1;
      end
    end
    case (st_r)
      lmx_pkg::RF_IDLE:
      begin
        if (step_r == '0)
        begin
          st_nxt = lmx_pkg::RF_PUSH;
        end
      end
      default:
      begin
        // a stalled receiver holds the row; steps missed meanwhile are dropped
        if (buf_rdy)
        begin
          st_nxt = lmx_pkg::RF_IDLE;
          row_nxt = row_r + 4'h1;
          if (row_r == 4'hf)
          begin
            sf_nxt = (sf_r == lmx_pkg::SF_LAST) ? '0 : sf_r + 4'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      st_r <= lmx_pkg::RF_IDLE;
      tick_r <= '0;
      sec_r <= '0;
      chg_r <= '0;
      plane_r <= '0;
      step_r <= '0;
      row_r <= '0;
      sf_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      tick_r <= tick_nxt;
      sec_r <= sec_nxt;
      chg_r <= chg_nxt;
      plane_r <= plane_nxt;
      step_r <= step_nxt;
      row_r <= row_nxt;
      sf_r <= sf_nxt;
    end
  end

  assign plane_o = plane_r;

  lmx_buf2 #(
    .W(12)
  ) u_buf (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .in_valid_i(st_r == lmx_pkg::RF_PUSH),
    .in_data_i({row_r, en}),
    .in_ready_o(buf_rdy),
    .out_valid_o(row_valid_o),
    .out_data_o({row_sel_o, row_data_o}),
    .out_ready_i(row_ready_i)
  );
endmodule
`default_nettype wire

/* File: inc/lmx_pkg.sv */
/*
  constants for the led matrix host command decoder: register indices,
  command field positions, memory sizes, timing counts and fsm states.
  assumes a 20 MHz system clock.
*/
`default_nettype none
package lmx_pkg;
  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int ROW_STEP_NS = 10_000;
  localparam int ROW_STEP_CYC = ROW_STEP_NS / CLK_PERIOD_NS;
  localparam int PLANE_RATE_HZ = 63;
  localparam int PLANE_TICK_CYC = CLK_HZ / PLANE_RATE_HZ;
  localparam int TICKS_PER_SEC = 63;
  localparam logic [3:0] SF_LAST = 4'hb;
  // transmission lengths
  localparam logic [4:0] LEN_IND = 5'h08;
  localparam logic [4:0] LEN_CFG = 5'h10;
  localparam logic [4:0] LEN_DIR = 5'h18;
  localparam logic [4:0] LEN_SAT = 5'h19;
  // 16- and 24-bit command fields
  localparam int CMD_RW = 15;
  localparam int CMD_AI = 14;
  localparam int CMD_GLOB = 13;
  localparam int CMD_RSV = 12;
  localparam int DIR_RW = 23;
  // register indices
  localparam logic [3:0] REG_PANEL = 4'h1;
  localparam logic [3:0] REG_PLANE = 4'h2;
  localparam logic [3:0] REG_RATE = 4'h3;
  localparam logic [3:0] REG_DRV_PTR = 4'h8;
  localparam logic [3:0] REG_DISP_LO = 4'h9;
  localparam logic [3:0] REG_DISP_HI = 4'ha;
  localparam logic [7:0] REG_RST = 8'h00;
  // field positions
  localparam int PNL_COLOR = 0;
  localparam int PNL_PI = 1;
  localparam int PNL_GEO_RED = 2;
  localparam int PNL_GEO_GRN = 3;
  localparam int PLN_AUTO = 6;
  localparam int RATE_SEC = 7;
  // intensity levels
  localparam logic [1:0] LVL_FULL = 2'h3;
  localparam logic [1:0] LVL_HI = 2'h2;
  localparam logic [1:0] LVL_LO = 2'h1;
  localparam int MEM_BYTES = 64;
  localparam int NUM_REGS = 16;
  typedef enum logic {RF_IDLE, RF_PUSH} lmx_rf_state_type;
endpackage
`default_nettype wire
